//--- src/rbm_pkg.sv
// Package with constants for the reset, boot and memory decode block.
package rbm_pkg;
  // Reset stretch after supply good, in instruction clocks.
  localparam int unsigned RESET_STRETCH_CYCLES = 65536;
  // Boot vectors.
  localparam logic [13:0] MONITOR_START_ADDR   = 14'h0800;
  localparam logic [13:0] FLASH_APP_ADDR       = 14'h2200;
  // Program memory decode bounds.
  localparam logic [13:0] PM_RAM_LAST          = 14'h01FF;
  localparam logic [13:0] PM_ROM_FIRST         = 14'h0800;
  localparam logic [13:0] PM_ROM_LAST          = 14'h17FF;
  localparam logic [13:0] FLASH_SEC0_FIRST     = 14'h2000;
  localparam logic [13:0] FLASH_SEC1_FIRST     = 14'h2100;
  localparam logic [13:0] FLASH_SEC2_FIRST     = 14'h2200;
  localparam logic [13:0] FLASH_SEC2_LAST      = 14'h2FFF;
  // Data memory decode bounds.
  localparam logic [13:0] DM_PERIPH_FIRST      = 14'h2000;
  localparam logic [13:0] DM_PERIPH_LAST       = 14'h20FF;
  localparam logic [13:0] DM_RAM_FIRST         = 14'h3800;
  localparam logic [13:0] DM_RAM_LAST          = 14'h39FF;
  // Core control registers.
  localparam logic [13:0] WAIT_STATE_CONTROL_ADDR = 14'h3FFE;
  localparam logic [13:0] SYSTEM_CONTROL_ADDR     = 14'h3FFF;
  localparam logic [15:0] WAIT_STATE_RESET        = 16'hFFFF;
  localparam logic [15:0] SYSTEM_CONTROL_RESET    = 16'h0000;
  localparam int unsigned SERIAL_PORT_SEL_BIT     = 10;
  // Interrupt sources.
  localparam int unsigned CORE_IRQ_COUNT   = 5;
  localparam int unsigned PERIPH_IRQ_COUNT = 11;
  localparam int unsigned IRQ_COUNT        = 16;
  // Sequencer states.
  typedef enum logic [3:0] {
    ST_RESET   = 4'h1,
    ST_MONITOR = 4'h2,
    ST_FLASH   = 4'h4,
    ST_EXTBOOT = 4'h8
  } rbm_state_t;
endpackage : rbm_pkg

//--- src/rbm_irq_merge.sv
// Interrupt masking, peripheral merge and fixed priority resolution.
`timescale 1ns/10ps
module rbm_irq_merge #(
  parameter int unsigned CORE_N   = 5,
  parameter int unsigned PERIPH_N = 11
) (
  input  wire logic                       clk_i,
  input  wire logic                       reset_n_i,
  input  wire logic                       sync_clear_i,
  input  wire logic [CORE_N-1:0]          core_irq_i,
  input  wire logic [PERIPH_N-1:0]        periph_irq_i,
  input  wire logic [CORE_N+PERIPH_N-1:0] irq_mask_i,
  output logic                            peripheral_irq_line_o,
  output logic                            irq_valid_o,
  output logic [4:0]                      irq_id_o
);
  localparam int unsigned N = CORE_N + PERIPH_N;
  logic [N-1:0] pending;
  logic         next_line;
  logic         next_valid;
  logic [4:0]   next_id;

  // Lowest index wins; masked sources never reach the core.
  always_comb begin
    pending    = {periph_irq_i, core_irq_i} & irq_mask_i;
    next_line  = |pending[N-1:CORE_N];
    next_valid = |pending;
    next_id    = 5'h00;
    for (int i = N - 1; i >= 0; i--) begin
      if (pending[i]) begin
        next_id = 5'(i);
      end
    end
  end

  // Registered so the core sees a glitch-free request.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      peripheral_irq_line_o <= 1'b0;
      irq_valid_o           <= 1'b0;
      irq_id_o              <= 5'h00;
    end else if (sync_clear_i) begin
      peripheral_irq_line_o <= 1'b0;
      irq_valid_o           <= 1'b0;
      irq_id_o              <= 5'h00;
    end else begin
      peripheral_irq_line_o <= next_line;
      irq_valid_o           <= next_valid;
      irq_id_o              <= next_id;
    end
  end
endmodule : rbm_irq_merge

//--- src/rbm_reset_boot.sv
// Reset stretcher, boot sequencer, memory decoder and core control registers.
// How it works
// - After supply good, reset holds for 65536 more instruction clocks.
// - External reset pin low at any time restarts full hardware reset.
// - Reset empties stacks, masks interrupts, clears mode status, resets peripherals.
// - Fetch starts at internal ROM address 0x0800 after reset.
// - Boot-from-flash code set makes the monitor jump to 0x2200.
// - Code clear makes the monitor try an external boot.
// - Code set blocks the external programmer and debugger.
// - Flash decodes as sectors of 256, 256 and 3584 words.
// - Peripheral registers at data 0x2000-0x20FF, user RAM at 0x3800-0x39FF.
// - Sixteen sources; eleven peripheral requests merge onto one core line.
// - Fixed priority and a separate mask for each source.
// - System control bit 10 selects serial port versus flags and interrupts.
// - Wait-state control register resets to 0xFFFF.
// - Four nonvolatile user bytes, reading zero after erase.
// - All timing runs at the doubled instruction clock rate.
`timescale 1ns/10ps
module rbm_reset_boot #(
  parameter int unsigned STRETCH_CYCLES = rbm_pkg::RESET_STRETCH_CYCLES,
  parameter int unsigned CORE_N         = rbm_pkg::CORE_IRQ_COUNT,
  parameter int unsigned PERIPH_N       = rbm_pkg::PERIPH_IRQ_COUNT
) (
  input  wire logic                       clk_i,
  input  wire logic                       reset_n_i,
  input  wire logic                       ext_reset_n_i,
  input  wire logic                       supply_good_i,
  input  wire logic                       boot_from_flash_i,
  input  wire logic                       ext_boot_done_i,
  input  wire logic                       debug_req_i,
  input  wire logic [7:0]                 nv_byte0_i,
  input  wire logic [7:0]                 nv_byte1_i,
  input  wire logic [7:0]                 nv_byte2_i,
  input  wire logic [7:0]                 nv_byte3_i,
  input  wire logic [13:0]                pm_addr_i,
  input  wire logic [13:0]                dm_addr_i,
  input  wire logic                       dm_wr_i,
  input  wire logic                       dm_rd_i,
  input  wire logic [15:0]                dm_wdata_i,
  input  wire logic [CORE_N-1:0]          core_irq_i,
  input  wire logic [PERIPH_N-1:0]        periph_irq_i,
  input  wire logic [CORE_N+PERIPH_N-1:0] irq_mask_i,
  output logic                            sys_reset_o,
  output logic                            stack_clear_o,
  output logic                            mode_status_clear_o,
  output logic                            irq_mask_force_o,
  output logic                            fetch_load_o,
  output logic [13:0]                     fetch_addr_o,
  output logic                            ext_boot_req_o,
  output logic                            debug_grant_o,
  output logic                            instruction_clock_out_o,
  output logic                            pm_ram_sel_o,
  output logic                            pm_rom_sel_o,
  output logic [2:0]                      flash_sector_sel_o,
  output logic [11:0]                     flash_word_o,
  output logic                            dm_periph_sel_o,
  output logic                            dm_ram_sel_o,
  output logic [15:0]                     dm_rdata_o,
  output logic                            sport_as_serial_o,
  output logic [15:0]                     wait_state_control_o,
  output logic [7:0]                      nv_user_byte_o,
  output logic                            peripheral_irq_line_o,
  output logic                            irq_valid_o,
  output logic [4:0]                      irq_id_o
);
  // Counter is wide enough for the full stretch, so the last count is always reachable.
  localparam int unsigned CW = $clog2(STRETCH_CYCLES + 1);
  localparam logic [CW-1:0] STRETCH_LAST = CW'(STRETCH_CYCLES - 1);

  // Window test shared by every decoder except the program RAM select.
  // Both bounds are inclusive, matching how the memory map lists its ranges.
  function automatic logic in_range(input logic [13:0] a, input logic [13:0] lo, input logic [13:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction : in_range

  // Stretch counter and reset sequencer state.
  // The counter only ever counts up, so one compare marks the end of the stretch.
  logic [CW-1:0]        cnt;
  logic [CW-1:0]        next_cnt;
  logic                 held;
  logic                 next_held;
  rbm_pkg::rbm_state_t  state;
  rbm_pkg::rbm_state_t  next_state;
  logic                 next_fetch_load;
  logic [13:0]          next_fetch_addr;
  logic                 next_ext_boot;
  logic                 next_debug;
  logic                 reset_cause;
  logic                 release_pulse;

  // Both reset sources are sampled on this clock, so release is synchronous.
  // The count freezes at its last value once released, so it cannot wrap into a new reset.
  always_comb begin
    reset_cause   = !ext_reset_n_i || !supply_good_i;
    next_cnt      = cnt;
    next_held     = held;
    release_pulse = 1'b0;
    if (reset_cause) begin
      next_cnt  = '0;
      next_held = 1'b1;
    end else if (held) begin
      if (cnt == STRETCH_LAST) begin
        next_held     = 1'b0;
        release_pulse = 1'b1;
      end else begin
        next_cnt = cnt + CW'(1);
      end
    end
  end

  // The test reset only parks the counter; the functional stretch still runs afterwards.
  // That way a supply that is already good still sees the full hold time.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt  <= '0;
      held <= 1'b1;
    end else begin
      cnt  <= next_cnt;
      held <= next_held;
    end
  end

  // Boot sequencer stands in for the monitor's branch decision.
  // It models only the branch, not the monitor's own instruction stream.
  always_comb begin
    next_state      = state;
    next_fetch_load = 1'b0;
    next_fetch_addr = fetch_addr_o;
    next_ext_boot   = 1'b0;
    next_debug      = 1'b0;
    unique case (state)
      // Wait here until the stretch counter lets go.
      rbm_pkg::ST_RESET: begin
        if (release_pulse) begin
          next_state      = rbm_pkg::ST_MONITOR;
          next_fetch_load = 1'b1;
          next_fetch_addr = rbm_pkg::MONITOR_START_ADDR;
        end
      end
      // The boot code is sampled once, on the first cycle after release.
      rbm_pkg::ST_MONITOR: begin
        next_fetch_load = 1'b1;
        if (boot_from_flash_i) begin
          next_state      = rbm_pkg::ST_FLASH;
          next_fetch_addr = rbm_pkg::FLASH_APP_ADDR;
        end else begin
          next_state      = rbm_pkg::ST_EXTBOOT;
          next_fetch_load = 1'b0;
          next_ext_boot   = 1'b1;
        end
      end
      // The application runs from flash; the debugger stays locked out.
      rbm_pkg::ST_FLASH: begin
        next_debug = 1'b0;
      end
      // Stays here until the next reset; the request drops once the loader reports completion.
      rbm_pkg::ST_EXTBOOT: begin
        next_ext_boot = !ext_boot_done_i;
        next_debug    = debug_req_i && !boot_from_flash_i;
      end
      // A corrupted one-hot code falls back to reset instead of hanging.
      default: begin
        next_state = rbm_pkg::ST_RESET;
      end
    endcase
    // Uses the next hold level, so the release edge itself can leave the reset state.
    if (next_held) begin
      next_state      = rbm_pkg::ST_RESET;
      next_fetch_load = 1'b0;
      next_ext_boot   = 1'b0;
      next_debug      = 1'b0;
    end
  end

  // Boot outputs are registered so the fetch unit sees clean one-cycle loads.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state         <= rbm_pkg::ST_RESET;
      fetch_load_o  <= 1'b0;
      fetch_addr_o  <= rbm_pkg::MONITOR_START_ADDR;
      ext_boot_req_o <= 1'b0;
      debug_grant_o <= 1'b0;
    end else begin
      state         <= next_state;
      fetch_load_o  <= next_fetch_load;
      fetch_addr_o  <= next_fetch_addr;
      ext_boot_req_o <= next_ext_boot;
      debug_grant_o <= next_debug;
    end
  end

  // One reset level drives every core and peripheral clear.
  // They share one flip-flop, so no clear can lag the others by a cycle.
  assign sys_reset_o         = held;
  assign stack_clear_o       = held;
  assign mode_status_clear_o = held;
  assign irq_mask_force_o    = held;

  // The clock is already the doubled rate, so the output simply follows it.
  // No multiplier is kept here: a half-rate input must be doubled before this block.
  assign instruction_clock_out_o = clk_i;

  // Core control registers, writable only when the core runs.
  logic [15:0] system_control;
  logic [15:0] next_system_control;
  logic [15:0] next_wait_state;
  logic [15:0] next_rdata;
  logic        sc_hit;
  logic        ws_hit;

  // Address matches are shared by the write and read paths.
  assign sc_hit = dm_addr_i == rbm_pkg::SYSTEM_CONTROL_ADDR;
  assign ws_hit = dm_addr_i == rbm_pkg::WAIT_STATE_CONTROL_ADDR;

  // Writes that arrive while the core is held are dropped; software reloads after reset.
  always_comb begin
    next_system_control = system_control;
    next_wait_state     = wait_state_control_o;
    next_rdata          = dm_rdata_o;
    if (held) begin
      next_system_control = rbm_pkg::SYSTEM_CONTROL_RESET;
      next_wait_state     = rbm_pkg::WAIT_STATE_RESET;
      next_rdata          = 16'h0000;
    end else begin
      if (dm_wr_i && sc_hit) begin
        next_system_control = dm_wdata_i;
      end
      if (dm_wr_i && ws_hit) begin
        next_wait_state = dm_wdata_i;
      end
      if (dm_rd_i) begin
        if (sc_hit) begin
          next_rdata = system_control;
        end else if (ws_hit) begin
          next_rdata = wait_state_control_o;
        end else begin
          next_rdata = 16'h0000;
        end
      end
    end
  end

  // Control registers and read data share the test reset.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      system_control       <= rbm_pkg::SYSTEM_CONTROL_RESET;
      wait_state_control_o <= rbm_pkg::WAIT_STATE_RESET;
      dm_rdata_o           <= 16'h0000;
    end else begin
      system_control       <= next_system_control;
      wait_state_control_o <= next_wait_state;
      dm_rdata_o           <= next_rdata;
    end
  end

  // The pin mode follows the stored bit directly, with no extra delay.
  assign sport_as_serial_o = system_control[rbm_pkg::SERIAL_PORT_SEL_BIT];

  // Address decoders are pure combinational selects.
  // The flash word offset is meaningful only while a sector select is high.
  always_comb begin
    pm_ram_sel_o          = pm_addr_i <= rbm_pkg::PM_RAM_LAST;
    pm_rom_sel_o          = in_range(pm_addr_i, rbm_pkg::PM_ROM_FIRST, rbm_pkg::PM_ROM_LAST);
    flash_sector_sel_o[0] = in_range(pm_addr_i, rbm_pkg::FLASH_SEC0_FIRST, rbm_pkg::FLASH_SEC1_FIRST - 14'h0001);
    flash_sector_sel_o[1] = in_range(pm_addr_i, rbm_pkg::FLASH_SEC1_FIRST, rbm_pkg::FLASH_SEC2_FIRST - 14'h0001);
    flash_sector_sel_o[2] = in_range(pm_addr_i, rbm_pkg::FLASH_SEC2_FIRST, rbm_pkg::FLASH_SEC2_LAST);
    flash_word_o          = 12'(pm_addr_i - rbm_pkg::FLASH_SEC0_FIRST);
    dm_periph_sel_o       = in_range(dm_addr_i, rbm_pkg::DM_PERIPH_FIRST, rbm_pkg::DM_PERIPH_LAST);
    dm_ram_sel_o          = in_range(dm_addr_i, rbm_pkg::DM_RAM_FIRST, rbm_pkg::DM_RAM_LAST);
  end

  // User byte picked by the low address bits; erased bytes arrive as zero.
  // Higher addresses wrap onto the same four bytes, since only two bits are decoded.
  always_comb begin
    unique case (dm_addr_i[1:0])
      2'h0: nv_user_byte_o = nv_byte0_i;
      2'h1: nv_user_byte_o = nv_byte1_i;
      2'h2: nv_user_byte_o = nv_byte2_i;
      2'h3: nv_user_byte_o = nv_byte3_i;
    endcase
  end

  // Interrupt merge is held quiet through reset.
  // Clearing on the hold level keeps a stale request from firing at boot.
  rbm_irq_merge #(
    .CORE_N   (CORE_N),
    .PERIPH_N (PERIPH_N)
  ) u_irq (
    .clk_i                 (clk_i),
    .reset_n_i             (reset_n_i),
    .sync_clear_i          (held),
    .core_irq_i            (core_irq_i),
    .periph_irq_i          (periph_irq_i),
    .irq_mask_i            (irq_mask_i),
    .peripheral_irq_line_o (peripheral_irq_line_o),
    .irq_valid_o           (irq_valid_o),
    .irq_id_o              (irq_id_o)
  );
endmodule : rbm_reset_boot

//--- tb/rbm_reset_boot_chk.sv
// Checker for reset stretch, boot vectors, memory decode and interrupt merge.
`timescale 1ns/10ps
module rbm_reset_boot_chk #(
  parameter int unsigned STRETCH_CYCLES = 8,
  parameter int unsigned CORE_N         = 5,
  parameter int unsigned PERIPH_N       = 11
) (
  input wire logic                       clk_i,
  input wire logic                       reset_n_i,
  input wire logic                       ext_reset_n_i,
  input wire logic                       supply_good_i,
  input wire logic                       boot_from_flash_i,
  input wire logic [13:0]                pm_addr_i,
  input wire logic [13:0]                dm_addr_i,
  input wire logic [PERIPH_N-1:0]        periph_irq_i,
  input wire logic [CORE_N+PERIPH_N-1:0] irq_mask_i,
  input wire logic                       sys_reset_o,
  input wire logic                       stack_clear_o,
  input wire logic                       mode_status_clear_o,
  input wire logic                       irq_mask_force_o,
  input wire logic                       fetch_load_o,
  input wire logic [13:0]                fetch_addr_o,
  input wire logic                       ext_boot_req_o,
  input wire logic                       debug_grant_o,
  input wire logic [2:0]                 flash_sector_sel_o,
  input wire logic                       dm_periph_sel_o,
  input wire logic                       dm_ram_sel_o,
  input wire logic                       peripheral_irq_line_o
);
  logic [16:0] good_cnt;
  logic [16:0] next_good_cnt;
  logic        periph_pend;
  // Edges with both reset sources good, saturating so a long run cannot wrap.
  always_comb begin
    next_good_cnt = good_cnt;
    if (!(ext_reset_n_i && supply_good_i)) next_good_cnt = '0;
    else if (good_cnt < STRETCH_CYCLES) next_good_cnt = good_cnt + 17'h00001;
  end
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) good_cnt <= '0;
    else good_cnt <= next_good_cnt;
  end
  // Peripheral requests that survive their masks.
  assign periph_pend = |(periph_irq_i & irq_mask_i[CORE_N+PERIPH_N-1:CORE_N]);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  sequence s_release;
    $fell(sys_reset_o) ##0 fetch_load_o;
  endsequence
  property p_hold; (good_cnt < STRETCH_CYCLES) |-> sys_reset_o; endproperty
  property p_free; (good_cnt == STRETCH_CYCLES) |-> !sys_reset_o; endproperty
  property p_pin; !ext_reset_n_i |=> sys_reset_o; endproperty
  property p_clear; {stack_clear_o, mode_status_clear_o, irq_mask_force_o} == {3{sys_reset_o}}; endproperty
  property p_vec; s_release |-> fetch_addr_o == rbm_pkg::MONITOR_START_ADDR; endproperty
  property p_flash;
    s_release ##0 boot_from_flash_i |=> fetch_load_o && fetch_addr_o == rbm_pkg::FLASH_APP_ADDR;
  endproperty
  property p_extboot; s_release ##0 !boot_from_flash_i |=> ext_boot_req_o; endproperty
  property p_lock; boot_from_flash_i |=> !debug_grant_o; endproperty
  property p_sector;
    flash_sector_sel_o == {pm_addr_i inside {[rbm_pkg::FLASH_SEC2_FIRST:rbm_pkg::FLASH_SEC2_LAST]},
      pm_addr_i inside {[rbm_pkg::FLASH_SEC1_FIRST:14'h21FF]}, pm_addr_i inside {[14'h2000:14'h20FF]}};
  endproperty
  property p_dmap;
    {dm_periph_sel_o, dm_ram_sel_o} == {dm_addr_i inside {[14'h2000:14'h20FF]}, dm_addr_i inside {[14'h3800:14'h39FF]}};
  endproperty
  property p_irq; !sys_reset_o && !$past(sys_reset_o) |-> peripheral_irq_line_o == $past(periph_pend); endproperty
  a_hold: assert property (p_hold) else $error("reset released early");
  a_free: assert property (p_free) else $error("reset not released");
  a_pin: assert property (p_pin) else $error("pin reset ignored");
  a_clear: assert property (p_clear) else $error("reset side effects wrong");
  a_vec: assert property (p_vec) else $error("wrong start address");
  a_flash: assert property (p_flash) else $error("no jump to flash");
  a_extboot: assert property (p_extboot) else $error("no external boot");
  a_sector: assert property (p_sector) else $error("flash sector decode wrong");
  a_dmap: assert property (p_dmap) else $error("data decode wrong");
  a_irq: assert property (p_irq) else $error("peripheral line wrong");
  a_lock: assert property (p_lock) else $error("debugger not locked out");
endmodule : rbm_reset_boot_chk

//--- tb/rbm_reset_boot_tb.sv
// Self-checking testbench for the reset, boot and memory decode block.
`timescale 1ns/10ps
module rbm_reset_boot_tb;
  localparam int unsigned STRETCH = 8;
  localparam logic [13:0] DEC_A [17] = '{14'h01FF, 14'h0200, 14'h0800, 14'h17FF, 14'h1800, 14'h1FFF, 14'h2000,
    14'h20FF, 14'h2100, 14'h21FF, 14'h2200, 14'h2FFF, 14'h3000, 14'h37FF, 14'h3800, 14'h39FF, 14'h3A00};
  localparam logic [6:0] DEC_E [17] = '{7'h40, 7'h00, 7'h20, 7'h20, 7'h00, 7'h00, 7'h06, 7'h06, 7'h08, 7'h08,
    7'h10, 7'h10, 7'h00, 7'h00, 7'h01, 7'h01, 7'h00};
  logic clk_i, reset_n_i, ext_reset_n_i, supply_good_i, boot_from_flash_i, ext_boot_done_i, debug_req_i, dm_wr_i;
  logic dm_rd_i, sys_reset_o, stack_clear_o, mode_status_clear_o, irq_mask_force_o, fetch_load_o, ext_boot_req_o;
  logic debug_grant_o, instruction_clock_out_o, pm_ram_sel_o, pm_rom_sel_o, dm_periph_sel_o, dm_ram_sel_o;
  logic sport_as_serial_o, peripheral_irq_line_o, irq_valid_o;
  logic [7:0]  nv_byte0_i, nv_byte1_i, nv_byte2_i, nv_byte3_i, nv_user_byte_o;
  logic [13:0] pm_addr_i, dm_addr_i, fetch_addr_o;
  logic [15:0] dm_wdata_i, irq_mask_i, dm_rdata_o, wait_state_control_o;
  logic [4:0]  core_irq_i, irq_id_o;
  logic [10:0] periph_irq_i;
  logic [2:0]  flash_sector_sel_o;
  logic [11:0] flash_word_o;
  int          miscompares = 0;
  int          total_checks = 0;
  int          cycle_count = 0;
  rbm_reset_boot #(.STRETCH_CYCLES(STRETCH)) u_rbm_reset_boot (.*);
  // Clock toggles every half period.
  always #2.5 clk_i = ~clk_i;
  // A hang is cut short well after the expected run of under two hundred cycles.
  always @(posedge clk_i) begin
    cycle_count++;
    if (cycle_count == 3000) begin
      miscompares++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    if (miscompares == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [13:0] a, input logic [15:0] d);
    @(negedge clk_i);
    dm_addr_i = a;
    dm_wdata_i = d;
    dm_wr_i = 1'b1;
    @(negedge clk_i);
    dm_wr_i = 1'b0;
  endtask : wr
  task automatic rd(input logic [13:0] a, input logic [15:0] e);
    @(negedge clk_i);
    dm_addr_i = a;
    dm_rd_i = 1'b1;
    @(negedge clk_i);
    dm_rd_i = 1'b0;
    chk(dm_rdata_o, e);
  endtask : rd
  task automatic irq_set(input logic [15:0] s, input logic [15:0] m);
    @(negedge clk_i);
    core_irq_i = s[4:0];
    periph_irq_i = s[15:5];
    irq_mask_i = m;
    @(negedge clk_i);
  endtask : irq_set
  // Resets through one source, optionally restarts the stretch midway, then follows the boot.
  task automatic run_boot(input logic flash, input bit via_supply, input bit abort);
    int n;
    n = 0;
    @(negedge clk_i);
    boot_from_flash_i = flash;
    if (via_supply) supply_good_i = 1'b0;
    else ext_reset_n_i = 1'b0;
    @(negedge clk_i);
    chk(sys_reset_o, 1'b1);
    chk({stack_clear_o, mode_status_clear_o, irq_mask_force_o}, 3'h7);
    ext_reset_n_i = 1'b1;
    supply_good_i = 1'b1;
    if (abort) begin
      repeat (STRETCH / 2) @(negedge clk_i);
      ext_reset_n_i = 1'b0;
      @(negedge clk_i);
      ext_reset_n_i = 1'b1;
    end
    while (sys_reset_o === 1'b1 && n < 4 * STRETCH) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    chk(n, STRETCH);
    chk({fetch_load_o, fetch_addr_o}, {1'b1, rbm_pkg::MONITOR_START_ADDR});
    @(posedge clk_i);
    #1;
    if (flash) chk({fetch_load_o, fetch_addr_o}, {1'b1, rbm_pkg::FLASH_APP_ADDR});
    else chk(ext_boot_req_o, 1'b1);
    repeat (2) @(posedge clk_i);
    #1;
    chk(debug_grant_o, !flash);
  endtask : run_boot
  // Main sequence; the debugger keeps asking so the lockout is visible.
  initial begin
    {clk_i, reset_n_i, supply_good_i, ext_boot_done_i, dm_wr_i, dm_rd_i} = '0;
    {ext_reset_n_i, boot_from_flash_i, debug_req_i} = 3'h7;
    {nv_byte3_i, nv_byte2_i, nv_byte1_i, nv_byte0_i} = 32'h88442211;
    {pm_addr_i, dm_addr_i, dm_wdata_i, core_irq_i, periph_irq_i, irq_mask_i} = '0;
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    reset_n_i = 1'b1;
    chk(wait_state_control_o, rbm_pkg::WAIT_STATE_RESET);
    run_boot(1'b1, 1'b1, 1'b0);
    rd(rbm_pkg::WAIT_STATE_CONTROL_ADDR, 16'hFFFF);
    wr(rbm_pkg::WAIT_STATE_CONTROL_ADDR, 16'h8000);
    rd(rbm_pkg::WAIT_STATE_CONTROL_ADDR, 16'h8000);
    wr(rbm_pkg::SYSTEM_CONTROL_ADDR, 16'h0400);
    chk(sport_as_serial_o, 1'b1);
    rd(rbm_pkg::SYSTEM_CONTROL_ADDR, 16'h0400);
    wr(rbm_pkg::SYSTEM_CONTROL_ADDR, 16'h0000);
    chk(sport_as_serial_o, 1'b0);
    rd(14'h3FFD, 16'h0000);
    run_boot(1'b0, 1'b0, 1'b1);
    @(negedge clk_i);
    ext_boot_done_i = 1'b1;
    @(negedge clk_i);
    chk(ext_boot_req_o, 1'b0);
    rd(rbm_pkg::WAIT_STATE_CONTROL_ADDR, 16'hFFFF);
    wr(rbm_pkg::WAIT_STATE_CONTROL_ADDR, 16'h8000);
    rd(14'h3C00, 16'h0000);
    foreach (DEC_A[k]) begin
      @(negedge clk_i);
      pm_addr_i = DEC_A[k];
      dm_addr_i = DEC_A[k];
      #1;
      chk({pm_ram_sel_o, pm_rom_sel_o, flash_sector_sel_o, dm_periph_sel_o, dm_ram_sel_o}, DEC_E[k]);
      if (DEC_E[k][4:2] != 3'h0) chk(flash_word_o, 12'(DEC_A[k] - rbm_pkg::FLASH_SEC0_FIRST));
    end
    for (int i = 0; i < 16; i++) begin
      irq_set(16'h0001 << i, 16'hFFFF);
      chk({irq_valid_o, irq_id_o, peripheral_irq_line_o}, {1'b1, 5'(i), i >= 5});
      irq_set((16'h0001 << i) | 16'h8000, 16'hFFFF);
      chk(irq_id_o, 5'(i));
      irq_set(16'h0001 << i, ~(16'h0001 << i));
      chk(irq_valid_o, 1'b0);
    end
    for (int j = 0; j < 4; j++) begin
      @(negedge clk_i);
      dm_addr_i = 14'h3C00 + 14'(j);
      #1;
      chk(nv_user_byte_o, 8'(8'h11 << j));
    end
    @(negedge clk_i);
    nv_byte3_i = 8'h00;
    #1;
    chk(nv_user_byte_o, 8'h00);
    @(posedge clk_i);
    #1;
    chk(instruction_clock_out_o, clk_i);
    give_verdict();
  end
endmodule : rbm_reset_boot_tb
// Attaches the checker to every instance of the block.
bind rbm_reset_boot rbm_reset_boot_chk #(.STRETCH_CYCLES(STRETCH_CYCLES), .CORE_N(CORE_N), .PERIPH_N(PERIPH_N))
  u_rbm_reset_boot_chk (.*);
